//--- hdl/cwb_pkg.sv
// constants and types shared by the colour balance block
package cwb_pkg;
    localparam logic [31:0] CWB_REG_ADDR      = 32'hf0f0080c;
    // bit positions follow the bus convention: field bit [0] is data bit 31
    localparam int          CWB_BIT_PRESENT   = 31;
    localparam int          CWB_BIT_ABS       = 30;
    localparam int          CWB_BIT_ONESHOT   = 26;
    localparam int          CWB_BIT_ON        = 25;
    localparam int          CWB_BIT_MODE      = 24;
    localparam int          CWB_UB_LSB        = 12;
    localparam int          CWB_VR_LSB        = 0;
    localparam int          CWB_GAIN_W        = 12;
    localparam int          CWB_SAMPLE_W      = 14;
    localparam int          CWB_LUT_IN_W      = 12;
    localparam int          CWB_LUT_OUT_W     = 10;
    localparam int          CWB_SUM_W         = 36;
    localparam int          CWB_POS_W         = 12;
    localparam logic [11:0] CWB_GAIN_MAX      = 12'h238;
    localparam logic [11:0] CWB_GAIN_UNITY    = 12'h11c;
    // 2^16 / 284 rounded, turns gain code into a 16-bit fraction of unity
    localparam logic [7:0]  CWB_UNITY_RECIP   = 8'he7;
    localparam logic [3:0]  CWB_SHOT_FRAMES   = 4'h9;
    localparam logic [7:0]  CWB_SHOT_STEP0    = 8'h80;
    localparam logic [11:0] CWB_AUTO_STEP     = 12'h001;
    localparam logic        CWB_RST_ON        = 1'b0;
    localparam logic        CWB_RST_MODE      = 1'b0;
    localparam logic        CWB_RST_ABS       = 1'b0;
    localparam longint      CWB_CLK_HZ        = 100000000;
    localparam longint      CWB_TIMEOUT_S     = 10;
    localparam longint      CWB_TIMEOUT_CYC   = CWB_TIMEOUT_S * CWB_CLK_HZ;
    localparam logic [1:0]  CWB_CH_R          = 2'h0;
    localparam logic [1:0]  CWB_CH_G          = 2'h1;
    localparam logic [1:0]  CWB_CH_B          = 2'h2;

    typedef enum logic [1:0] {CWB_IDLE, CWB_SHOT, CWB_AUTO} cwb_state_e;
endpackage : cwb_pkg

//--- hdl/cwb_acc_if.sv
// link between the balance control and the colour sum accumulator
`timescale 1ns/100ps
interface cwb_acc_if;
    import cwb_pkg::*;
    logic                   clear;
    logic                   add;
    logic [1:0]             chan;
    logic [CWB_SAMPLE_W-1:0] sample;
    logic [CWB_SUM_W-1:0]   sum_r;
    logic [CWB_SUM_W-1:0]   sum_g;
    logic [CWB_SUM_W-1:0]   sum_b;
    modport ctl (output clear, output add, output chan, output sample,
                 input sum_r, input sum_g, input sum_b);
    modport acc (input clear, input add, input chan, input sample,
                 output sum_r, output sum_g, output sum_b);
endinterface : cwb_acc_if

//--- hdl/cwb_accum.sv
// per-colour sample sums over the evaluation area
`timescale 1ns/100ps
module cwb_accum
    import cwb_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    cwb_acc_if.acc    acc
);
    typedef struct packed {
        logic [2:0][CWB_SUM_W-1:0] sum;
    } cwb_acc_s;

    cwb_acc_s st;
    cwb_acc_s next_st;

    always_comb
    begin
        next_st = st;
        for (int i = 0; i < 3; i++)
        begin
            if (acc.clear)
                next_st.sum[i] = '0;
            else if (acc.add && acc.chan == 2'(i))
                next_st.sum[i] = st.sum[i] + CWB_SUM_W'(acc.sample);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st <= '0;
        else if (ce)
            st <= next_st;
    end

    assign acc.sum_r = st.sum[CWB_CH_R];
    assign acc.sum_g = st.sum[CWB_CH_G];
    assign acc.sum_b = st.sum[CWB_CH_B];
endmodule : cwb_accum

//--- hdl/cwb_balance.sv
// colour balance control: register, lookup bypass, gains, one-shot and continuous loop
`timescale 1ns/100ps
// Summary of operation
// - lookup table off passes the whole 14-bit sample unchanged.
// - lookup table on keeps upper 12 bits, reduced to a 10-bit result.
// - presence bit reads whether the balance feature exists.
// - absolute-control bit selects absolute gains instead of the register fields.
// - writing one-shot starts one balance; bit reads 1 until done.
// - one-shot writes are ignored while automatic mode is selected.
// - on/off bit switches the feature and reads back its state.
// - mode bit selects manual (0) or automatic (1) and reads back.
// - blue gain high group, red gain low; writes ignored in auto or off.
// - each gain spans codes 0 to 568, about 0.0353 dB per code.
// - with both gains below 284 the smaller sets green gain.
// - one-shot balance generates its own frames with current settings.
// - one-shot balance processes exactly nine frames.
// - one-shot sums red, green, blue and steers gains toward equal sums.
// - with transmit enabled, one-shot frames also go out on the bus.
// - capture active before one-shot is restarted when it completes.
// - one-shot result gains are left readable in the register.
// - triggered continuous balance aborts after over 10 s between frames.
// - continuous balance may start during capture or while idle.
// - evaluation area serves all auto functions; disabled follows image.
// - continuous balance sums colours inside the area as loop feedback.
module cwb_balance
    import cwb_pkg::*;
#(
    parameter longint TIMEOUT_CYCLES = CWB_TIMEOUT_CYC,
    parameter logic   FEATURE_PRESENT = 1'b1
)
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire logic [31:0]             reg_addr,
    input  wire logic                    reg_wr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_rd,
    output logic      [31:0]             reg_rdata,
    input  wire logic [CWB_GAIN_W-1:0]   abs_ub,
    input  wire logic [CWB_GAIN_W-1:0]   abs_vr,
    input  wire logic                    lookup_table_on,
    input  wire logic                    pix_valid,
    input  wire logic [1:0]              pix_chan,
    input  wire logic [CWB_SAMPLE_W-1:0] pix_sample,
    input  wire logic [CWB_POS_W-1:0]    pix_x,
    input  wire logic [CWB_POS_W-1:0]    pix_y,
    input  wire logic                    frame_end,
    input  wire logic                    area_en,
    input  wire logic [CWB_POS_W-1:0]    area_x,
    input  wire logic [CWB_POS_W-1:0]    area_y,
    input  wire logic [CWB_POS_W-1:0]    area_w,
    input  wire logic [CWB_POS_W-1:0]    area_h,
    input  wire logic                    capture_active,
    input  wire logic                    isochronous_transmit_enable,
    input  wire logic                    ext_trigger_mode,
    output logic                         pix_out_valid,
    output logic      [CWB_SAMPLE_W-1:0] pix_out,
    output logic                         shot_frame_req,
    output logic                         shot_tx_en,
    output logic                         capture_restart,
    output logic                         auto_running
);
    localparam logic [29:0] TIMEOUT_CNT = 30'(TIMEOUT_CYCLES);

    typedef struct packed {
        cwb_state_e                 fsm;
        logic                       abs_ctl;
        logic                       on;
        logic                       mode;
        logic [CWB_GAIN_W-1:0]      ub;
        logic [CWB_GAIN_W-1:0]      vr;
        logic [3:0]                 frames;
        logic [7:0]                 step;
        logic                       cap_was;
        logic                       restart;
        logic [29:0]                idle_cnt;
        logic                       pix_vld;
        logic [CWB_SAMPLE_W-1:0]    pix;
        logic [31:0]                rdata;
    } cwb_main_s;

    cwb_main_s st;
    cwb_main_s next_st;

    cwb_acc_if acc_bus ();

    cwb_accum u_accum (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .acc (acc_bus.acc)
    );

    logic                    reg_hit;
    logic                    in_area;
    logic [CWB_SAMPLE_W-1:0] lut_sample;
    logic [CWB_GAIN_W-1:0]   g_ub;
    logic [CWB_GAIN_W-1:0]   g_vr;
    logic [CWB_GAIN_W-1:0]   g_green;
    logic [CWB_GAIN_W-1:0]   g_sel;
    logic [33:0]             scaled;
    logic [CWB_SAMPLE_W-1:0] gained;
    logic [CWB_GAIN_W-1:0]   upd_ub;
    logic [CWB_GAIN_W-1:0]   upd_vr;
    logic [CWB_GAIN_W-1:0]   step_w;
    logic [CWB_POS_W:0]      area_x_end;
    logic [CWB_POS_W:0]      area_y_end;

    assign reg_hit = (reg_addr == CWB_REG_ADDR);

    // one extra bit so a window that reaches the far edge does not wrap to zero
    assign area_x_end = {1'b0, area_x} + {1'b0, area_w};
    assign area_y_end = {1'b0, area_y} + {1'b0, area_h};

    // evaluation window; when disabled every active pixel counts
    assign in_area = !area_en ||
                     (pix_x >= area_x && {1'b0, pix_x} < area_x_end &&
                      pix_y >= area_y && {1'b0, pix_y} < area_y_end);

    assign acc_bus.clear  = frame_end;
    assign acc_bus.add    = pix_valid && in_area && st.fsm != CWB_IDLE;
    assign acc_bus.chan   = pix_chan;
    assign acc_bus.sample = pix_sample;

    // lookup path keeps the top 12 bits and reduces them to 10
    always_comb
    begin
        if (lookup_table_on)
            lut_sample = CWB_SAMPLE_W'(pix_sample[CWB_SAMPLE_W-1 -: CWB_LUT_OUT_W]);
        else
            lut_sample = pix_sample;
    end

    // gain source and green gain selection
    always_comb
    begin
        g_ub = st.abs_ctl ? abs_ub : st.ub;
        g_vr = st.abs_ctl ? abs_vr : st.vr;
        if (g_ub < CWB_GAIN_UNITY && g_vr < CWB_GAIN_UNITY)
            g_green = (g_ub < g_vr) ? g_ub : g_vr;
        else
            g_green = CWB_GAIN_UNITY;
        if (!st.on)
            g_sel = CWB_GAIN_UNITY;
        else if (pix_chan == CWB_CH_R)
            g_sel = g_vr;
        else if (pix_chan == CWB_CH_B)
            g_sel = g_ub;
        else
            g_sel = g_green;
        scaled = 34'(lut_sample) * 34'(g_sel) * 34'(CWB_UNITY_RECIP);
        if (|scaled[33:30])
            gained = '1;
        else
            gained = scaled[29:16];
    end

    // one loop step: move each side gain toward the green sum, clamped
    always_comb
    begin
        step_w = CWB_GAIN_W'(st.step);
        upd_ub = st.ub;
        upd_vr = st.vr;
        if (acc_bus.sum_b < acc_bus.sum_g)
            upd_ub = (CWB_GAIN_MAX - st.ub > step_w) ? st.ub + step_w : CWB_GAIN_MAX;
        else if (acc_bus.sum_b > acc_bus.sum_g)
            upd_ub = (st.ub > step_w) ? st.ub - step_w : '0;
        if (acc_bus.sum_r < acc_bus.sum_g)
            upd_vr = (CWB_GAIN_MAX - st.vr > step_w) ? st.vr + step_w : CWB_GAIN_MAX;
        else if (acc_bus.sum_r > acc_bus.sum_g)
            upd_vr = (st.vr > step_w) ? st.vr - step_w : '0;
    end

    always_comb
    begin
        next_st         = st;
        next_st.restart = 1'b0;
        next_st.pix_vld = pix_valid;
        if (pix_valid)
            next_st.pix = gained;

        if (reg_rd && reg_hit)
        begin
            next_st.rdata                   = '0;
            next_st.rdata[CWB_BIT_PRESENT]  = FEATURE_PRESENT;
            next_st.rdata[CWB_BIT_ABS]      = st.abs_ctl;
            next_st.rdata[CWB_BIT_ONESHOT]  = (st.fsm == CWB_SHOT);
            next_st.rdata[CWB_BIT_ON]       = st.on;
            next_st.rdata[CWB_BIT_MODE]     = st.mode;
            next_st.rdata[CWB_UB_LSB +: CWB_GAIN_W] = st.ub;
            next_st.rdata[CWB_VR_LSB +: CWB_GAIN_W] = st.vr;
        end

        // loop sequencing
        unique case (st.fsm)
            CWB_IDLE:
            begin
                next_st.idle_cnt = '0;
            end
            CWB_SHOT:
            begin
                if (frame_end)
                begin
                    next_st.ub     = upd_ub;
                    next_st.vr     = upd_vr;
                    next_st.frames = st.frames + 4'h1;
                    next_st.step   = (st.step > 8'h01) ? {1'b0, st.step[7:1]} : 8'h01;
                    if (st.frames + 4'h1 == CWB_SHOT_FRAMES)
                    begin
                        next_st.fsm     = CWB_IDLE;
                        next_st.restart = st.cap_was;
                    end
                end
            end
            CWB_AUTO:
            begin
                if (frame_end)
                begin
                    next_st.ub       = upd_ub;
                    next_st.vr       = upd_vr;
                    next_st.idle_cnt = '0;
                end
                else if (ext_trigger_mode)
                begin
                    if (st.idle_cnt == TIMEOUT_CNT)
                    begin
                        next_st.fsm  = CWB_IDLE;
                        next_st.mode = 1'b0;
                    end
                    else
                        next_st.idle_cnt = st.idle_cnt + 30'h1;
                end
                if (!st.on || !st.mode)
                    next_st.fsm = CWB_IDLE;
            end
            default:
                next_st.fsm = CWB_IDLE;
        endcase

        if (reg_wr && reg_hit)
        begin
            next_st.abs_ctl = reg_wdata[CWB_BIT_ABS];
            next_st.on      = reg_wdata[CWB_BIT_ON];
            next_st.mode    = reg_wdata[CWB_BIT_MODE];
            if (st.on && !st.mode && st.fsm != CWB_SHOT)
            begin
                next_st.ub = reg_wdata[CWB_UB_LSB +: CWB_GAIN_W];
                next_st.vr = reg_wdata[CWB_VR_LSB +: CWB_GAIN_W];
                if (next_st.ub > CWB_GAIN_MAX)
                    next_st.ub = CWB_GAIN_MAX;
                if (next_st.vr > CWB_GAIN_MAX)
                    next_st.vr = CWB_GAIN_MAX;
            end
            if (reg_wdata[CWB_BIT_ONESHOT] && !st.mode && !reg_wdata[CWB_BIT_MODE]
                && st.fsm == CWB_IDLE)
            begin
                next_st.fsm     = CWB_SHOT;
                next_st.frames  = '0;
                next_st.step    = CWB_SHOT_STEP0;
                next_st.cap_was = capture_active;
            end
            else if (reg_wdata[CWB_BIT_MODE] && reg_wdata[CWB_BIT_ON]
                     && st.fsm == CWB_IDLE)
            begin
                next_st.fsm      = CWB_AUTO;
                next_st.step     = 8'(CWB_AUTO_STEP);
                next_st.idle_cnt = '0;
            end
            // a stop ends the loop at once, so a frame in the same cycle moves no gain
            if (st.fsm == CWB_AUTO && !(reg_wdata[CWB_BIT_ON] && reg_wdata[CWB_BIT_MODE]))
            begin
                next_st.fsm      = CWB_IDLE;
                next_st.ub       = st.ub;
                next_st.vr       = st.vr;
                next_st.idle_cnt = '0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st         <= '0;
            st.fsm     <= CWB_IDLE;
            st.on      <= CWB_RST_ON;
            st.mode    <= CWB_RST_MODE;
            st.abs_ctl <= CWB_RST_ABS;
            st.ub      <= CWB_GAIN_UNITY;
            st.vr      <= CWB_GAIN_UNITY;
            st.step    <= CWB_SHOT_STEP0;
        end
        else if (ce)
            st <= next_st;
    end

    assign reg_rdata       = st.rdata;
    assign pix_out_valid   = st.pix_vld;
    assign pix_out         = st.pix;
    assign shot_frame_req  = (st.fsm == CWB_SHOT);
    assign shot_tx_en      = (st.fsm == CWB_SHOT) && isochronous_transmit_enable;
    assign capture_restart = st.restart;
    assign auto_running    = (st.fsm == CWB_AUTO);
endmodule : cwb_balance

//--- verification/cwb_host.sv
// host software model driving the colour balance register port
`timescale 1ns/100ps
module cwb_host
(
    input  wire logic        clk,
    input  wire logic [31:0] reg_rdata,
    output logic      [31:0] reg_addr,
    output logic             reg_wr,
    output logic      [31:0] reg_wdata,
    output logic             reg_rd
);
    initial
    begin
        reg_addr = 32'h0;
        reg_wr = 1'b0;
        reg_wdata = 32'h0;
        reg_rd = 1'b0;
    end
    // a released bus shows the inverse of its last value, never a stale copy
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(negedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(negedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(negedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        d = reg_rdata;
    endtask
endmodule // cwb_host

//--- verification/cwb_balance_checker.sv
// port assertions for the colour balance block
`timescale 1ns/100ps
module cwb_balance_checker
    import cwb_pkg::*;
#(
    parameter longint TIMEOUT_CYCLES  = CWB_TIMEOUT_CYC,
    parameter logic   FEATURE_PRESENT = 1'b1
)
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic [31:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        pix_valid,
    input wire logic        pix_out_valid,
    input wire logic        frame_end,
    input wire logic        shot_frame_req,
    input wire logic        shot_tx_en,
    input wire logic        capture_restart,
    input wire logic        auto_running,
    input wire logic        isochronous_transmit_enable,
    input wire logic        ext_trigger_mode
);
    logic [3:0]  shot_cnt;
    logic [31:0] idle_cnt;
    logic        hit_wr;
    logic        hit_rd;
    assign hit_wr = ce && reg_wr && reg_addr == CWB_REG_ADDR;
    assign hit_rd = ce && reg_rd && reg_addr == CWB_REG_ADDR;
    always_ff @(posedge clk)
    begin
        if (rst || !shot_frame_req)
            shot_cnt <= 4'h0;
        else if (ce && frame_end)
            shot_cnt <= shot_cnt + 4'h1;
        if (rst || !auto_running || !ext_trigger_mode || frame_end)
            idle_cnt <= 32'h0;
        else if (ce)
            idle_cnt <= idle_cnt + 32'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_last_frame;
        shot_frame_req && ce && frame_end && shot_cnt == 4'h8;
    endsequence
    sequence s_early_frame;
        shot_frame_req && ce && frame_end && shot_cnt < 4'h8;
    endsequence
    a_shot_ends_ninth: assert property (s_last_frame |=> !shot_frame_req)
        else $error("one-shot still running after ninth frame");
    a_shot_holds_early: assert property (s_early_frame |=> shot_frame_req)
        else $error("one-shot ended early");
    a_shot_auto_ignored: assert property (
        auto_running && hit_wr && reg_wdata[CWB_BIT_ONESHOT] |=> !shot_frame_req)
        else $error("one-shot started in auto mode");
    a_read_shot_bit: assert property (
        hit_rd |=> reg_rdata[CWB_BIT_ONESHOT] == $past(shot_frame_req))
        else $error("one-shot bit read wrong");
    a_presence_read: assert property (
        hit_rd |=> reg_rdata[CWB_BIT_PRESENT] == FEATURE_PRESENT && reg_rdata[29:27] == 3'h0)
        else $error("presence or reserved bits read wrong");
    a_tx_follows_shot: assert property (
        shot_tx_en == (shot_frame_req && isochronous_transmit_enable))
        else $error("transmit enable wrong during one-shot");
    a_restart_after_shot: assert property (
        capture_restart |-> $past(shot_frame_req) && !shot_frame_req ##1 !capture_restart)
        else $error("capture restart out of place");
    a_auto_stop_write: assert property (
        auto_running && hit_wr && !reg_wdata[CWB_BIT_ON] |=> !auto_running)
        else $error("auto loop kept running after off");
    a_abort_timeout: assert property (idle_cnt <= 32'(TIMEOUT_CYCLES) + 32'h2)
        else $error("auto loop not aborted after frame timeout");
    a_pixel_passes: assert property (ce && pix_valid |=> pix_out_valid)
        else $error("sample not passed on");
    a_reset_clears: assert property (disable iff (1'b0)
        rst |=> reg_rdata == 32'h0 && !shot_frame_req && !auto_running && !capture_restart)
        else $error("outputs not cleared by reset");
endmodule // cwb_balance_checker

//--- verification/cwb_balance_test.sv
// self-checking bench for the colour balance block
`timescale 1ns/100ps
module cwb_balance_test;
    import cwb_pkg::*;
    localparam longint      TMO = 50;
    localparam logic [31:0] A   = CWB_REG_ADDR;
    typedef struct packed {logic [31:0] a; logic [31:0] d; logic [31:0] e;} cwb_row_s;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [31:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic        reg_wr, reg_rd, pix_out_valid, shot_frame_req, shot_tx_en;
    logic        capture_restart, auto_running, seen;
    logic [11:0] abs_ub = 12'h0, abs_vr = 12'h238, pix_x = 12'h0, pix_y = 12'h0;
    logic [11:0] area_x = 12'h0, area_y = 12'h0, area_w = 12'h0, area_h = 12'h0;
    logic        lookup_table_on = 1'b0, pix_valid = 1'b0, frame_end = 1'b0, area_en = 1'b0;
    logic        capture_active = 1'b1, isochronous_transmit_enable = 1'b1;
    logic        ext_trigger_mode = 1'b0;
    logic [1:0]  pix_chan = 2'h0;
    logic [13:0] pix_sample = 14'h0, pix_out;
    logic [23:0] g;
    int          fail_count = 0, samples_checked = 0, n;
    cwb_row_s    rows [8] = '{
        '{A, 32'h0212_3045, 32'h8211_c11c}, '{A, 32'h0223_8000, 32'h8223_8000},
        '{A, 32'h02ff_f239, 32'h8223_8238}, '{A, 32'h0000_0111, 32'h8000_0111},
        '{A, 32'h0212_3456, 32'h8200_0111}, '{A, 32'h4200_0111, 32'hc200_0111},
        '{32'hf0f0_0810, 32'h0, 32'hc200_0111}, '{A, 32'h0206_40c8, 32'h8206_40c8}};
    always #5 clk = ~clk;
    cwb_host h_u (.clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
    cwb_balance #(.TIMEOUT_CYCLES(TMO)) dut_u (.clk, .rst, .ce, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .abs_ub, .abs_vr, .lookup_table_on, .pix_valid, .pix_chan,
        .pix_sample, .pix_x, .pix_y, .frame_end, .area_en, .area_x, .area_y, .area_w, .area_h,
        .capture_active, .isochronous_transmit_enable, .ext_trigger_mode, .pix_out_valid,
        .pix_out, .shot_frame_req, .shot_tx_en, .capture_restart, .auto_running);
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // expected gained sample, saturated to the 14-bit range
    function automatic logic [13:0] gx(input logic [13:0] s, input logic [11:0] k);
        logic [35:0] p;
        p = (36'(s) * 36'(k) * 36'd231) >> 16;
        gx = (p > 36'h3fff) ? 14'h3fff : p[13:0];
    endfunction
    task automatic px(input logic [1:0] c, input logic [13:0] s, input logic l,
                      input logic [13:0] e);
        @(negedge clk);
        pix_chan = c;
        pix_sample = s;
        pix_x = s[11:0];
        lookup_table_on = l;
        pix_valid = 1'b1;
        @(negedge clk);
        pix_valid = 1'b0;
        chk("pix_out", {17'h0, pix_out_valid, pix_out}, {17'h1, e});
    endtask
    task automatic frame();
        @(negedge clk);
        frame_end = 1'b1;
        @(negedge clk);
        frame_end = 1'b0;
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        fail_count++;
        print_verdict();
    end
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        h_u.rd(A, rv);
        chk("reset word", rv, 32'h8011_c11c);
        foreach (rows[i])
        begin
            h_u.wr(rows[i].a, rows[i].d);
            h_u.rd(A, rv);
            chk("register", rv, rows[i].e);
        end
        px(CWB_CH_R, 14'h1000, 1'b0, gx(14'h1000, 12'h0c8));
        px(CWB_CH_G, 14'h1000, 1'b0, gx(14'h1000, 12'h064));
        px(CWB_CH_R, 14'h3ffc, 1'b1, gx(14'h03ff, 12'h0c8));
        h_u.wr(A, 32'h4206_40c8);
        px(CWB_CH_R, 14'h3fff, 1'b0, gx(14'h3fff, 12'h238));
        h_u.wr(A, 32'h0606_40c8);
        chk("shot_tx_en", {31'h0, shot_tx_en}, 32'h1);
        h_u.rd(A, rv);
        chk("one-shot bit", {31'h0, rv[26]}, 32'h1);
        px(CWB_CH_R, 14'h1000, 1'b0, gx(14'h1000, 12'h0c8));
        repeat (8) frame();
        chk("shot_frame_req", {31'h0, shot_frame_req}, 32'h1);
        frame();
        seen = capture_restart;
        repeat (3)
        begin
            @(negedge clk);
            seen = seen | capture_restart;
        end
        chk("shot_frame_req", {31'h0, shot_frame_req}, 32'h0);
        chk("capture_restart", {31'h0, seen}, 32'h1);
        h_u.rd(A, rv);
        chk("result gains", rv, 32'h8206_4048);
        h_u.wr(A, 32'h0306_40c8);
        chk("auto_running", {31'h0, auto_running}, 32'h1);
        h_u.wr(A, 32'h0700_0000);
        chk("shot_frame_req", {31'h0, shot_frame_req}, 32'h0);
        area_en = 1'b1;
        area_w = 12'h010;
        area_h = 12'h010;
        px(CWB_CH_R, 14'h0100, 1'b0, gx(14'h0100, 12'h0c8));
        frame();
        px(CWB_CH_R, 14'h000f, 1'b0, gx(14'h000f, 12'h0c8));
        ext_trigger_mode = 1'b1;
        frame();
        h_u.rd(A, rv);
        chk("loop gains", rv, 32'h8306_40c7);
        g = rv[23:0];
        n = 0;
        while (auto_running === 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        chk("abort delay", {31'h0, n > TMO - 8 && n < TMO + 4}, 32'h1);
        h_u.rd(A, rv);
        chk("held gains", {7'h0, rv[24:0]}, {8'h0, g});
        ext_trigger_mode = 1'b0;
        h_u.wr(A, 32'h0306_40c8);
        h_u.wr(A, 32'h0000_0000);
        chk("auto stop", {31'h0, auto_running}, 32'h0);
        ce = 1'b0;
        h_u.wr(A, 32'h0200_0000);
        ce = 1'b1;
        h_u.rd(A, rv);
        chk("frozen write", rv, 32'h8006_40c8);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        h_u.rd(A, rv);
        chk("reset word", rv, 32'h8011_c11c);
        print_verdict();
    end
endmodule // cwb_balance_test
bind cwb_balance cwb_balance_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
    .FEATURE_PRESENT(FEATURE_PRESENT)) chk_u (.clk, .rst, .ce, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .pix_valid, .pix_out_valid, .frame_end, .shot_frame_req, .shot_tx_en,
    .capture_restart, .auto_running, .isochronous_transmit_enable, .ext_trigger_mode);
